// ==== verilog/ocdc_config_control.v ====
// Configuration control of the octal converter: readback, loads, soft reset, power-down and correction.
//
// Notes on behaviour
// R1: Readback select picks input or converter data.
// R2: Input keeps raw value; converter data corrected.
// R3: Sync load copies converter data to latches.
// R4: Only channels written since last load reload.
// R5: Sync load bit clears itself after updating.
// R6: Without correction, sync load updates at once.
// R7: Sync load writes ignored while load pin low.
// R8: Soft reset equals hardware reset, then clears itself.
// R9: Group A bit powers down channels 0-3.
// R10: Group B bit powers down channels 4-7.
// R11: Access port stays active during power-down.
// R12: Calibration on corrects input with gain, zero.
// R13: Calibration off passes input straight through.
// R14: Reserved bit ignores writes, reads zero.
// R15: Configuration resets to readback select set.
// R16: Group power-downs act independently.
`timescale 1ns/1ps
`include "ocdc_config_map.vh"

module ocdc_config_control (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        wr_req,
	input  wire [1:0]  wr_sel,
	input  wire [2:0]  wr_chan,
	input  wire [15:0] wr_data,
	input  wire        rd_req,
	input  wire        rd_sel_channel,
	input  wire [2:0]  rd_chan,
	output reg  [15:0] rd_data_reg,
	output reg         rd_valid_reg,
	input  wire        async_load_pin,
	output reg  [95:0] latch_data_reg,
	output wire        group_a_powerdown,
	output wire        group_b_powerdown,
	output wire        calibration_enable,
	output wire        sync_load_bit
);

	reg  [15:0] cfg_reg;          // Plain stored configuration bits.
	reg         sync_load_reg;    // Pending synchronous load command.
	reg         soft_reset_reg;   // Soft reset request, acted on in the next cycle.
	reg         load_s1_reg;      // First synchroniser stage of the load pin.
	reg         load_s2_reg;      // Second synchroniser stage of the load pin.
	reg  [95:0] input_flat_reg;   // Raw input codes of all channels.
	reg  [95:0] dac_flat_reg;     // Converter data codes of all channels.
	reg  [95:0] gain_flat_reg;    // Gain codes of all channels.
	reg  [95:0] zero_flat_reg;    // Zero codes of all channels.
	reg  [7:0]  accessed_reg;     // Channels written since the last load.
	wire        srst;             // Synchronous clear driven by the soft reset.
	wire        load_pin_low;     // Synchronised level of the load pin.
	wire        cfg_write;        // Configuration write this cycle.
	wire        cal_on;           // Correction engine enabled.
	wire        eng_done;         // Corrected result is ready.
	wire [2:0]  eng_chan;         // Channel of the corrected result.
	wire [11:0] eng_result;       // Corrected code.
	wire        eng_start;        // Input write that needs correcting.
	wire        sync_fire;        // Synchronous load is carried out this cycle.
	wire        load_now;         // Any latch update this cycle.
	wire [15:0] cfg_read;         // Configuration value as software reads it.

	// One decoder shared by the per-channel input, gain and zero write logic.
	function hit;
		input       req;
		input [1:0] sel;
		input [1:0] want;
		input [2:0] chan;
		input [2:0] idx;
		begin
			hit = req && (sel == want) && (chan == idx);
		end
	endfunction

	assign srst               = soft_reset_reg;
	assign load_pin_low       = ~load_s2_reg;
	assign cfg_write          = wr_req && (wr_sel == `OCDC_SEL_CONFIG);
	assign cal_on             = cfg_reg[`OCDC_BIT_CAL_EN];
	assign eng_start          = cal_on && wr_req && (wr_sel == `OCDC_SEL_INPUT); // R12
	// A pending load waits while a corrected result is still on its way, so it never loads stale data.
	assign sync_fire          = sync_load_reg && !eng_start && !eng_done; // R3
	assign load_now           = load_pin_low || sync_fire;
	assign group_a_powerdown  = cfg_reg[`OCDC_BIT_PD_A]; // R9
	assign group_b_powerdown  = cfg_reg[`OCDC_BIT_PD_B]; // R10 R16
	assign calibration_enable = cal_on;
	assign sync_load_bit      = sync_load_reg;
	// Reserved and unimplemented low bits are never stored, so they read as zero.
	assign cfg_read           = cfg_reg | ({15'h0000, sync_load_reg} << `OCDC_BIT_SYNC_LOAD)
	                            | ({15'h0000, soft_reset_reg} << `OCDC_BIT_SOFT_RESET); // R14

	// The load pin comes from outside the clock domain; only the second stage is read.
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			load_s1_reg <= 1'b1;
			load_s2_reg <= 1'b1;
		end
		else
		begin
			load_s1_reg <= async_load_pin;
			load_s2_reg <= load_s1_reg;
		end
	end

	// Configuration bits, the self-clearing load command and the soft reset request.
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cfg_reg        <= `OCDC_CFG_RESET; // R15
			sync_load_reg  <= 1'b0;
			soft_reset_reg <= 1'b0;
		end
		else if (srst)
		begin
			// Same state as after the hardware reset; the request bit drops with it.
			cfg_reg        <= `OCDC_CFG_RESET; // R8
			sync_load_reg  <= 1'b0;
			soft_reset_reg <= 1'b0;
		end
		else
		begin
			if (cfg_write)
			begin
				cfg_reg        <= wr_data & `OCDC_CFG_STORE_MASK; // R14
				soft_reset_reg <= wr_data[`OCDC_BIT_SOFT_RESET]; // R8
			end
			// A new command written in the cycle the old one fires is kept, not lost.
			if (cfg_write && wr_data[`OCDC_BIT_SYNC_LOAD] && !load_pin_low)
				sync_load_reg <= 1'b1; // R6
			else if (load_pin_low)
				sync_load_reg <= 1'b0; // R7
			else if (sync_fire)
				sync_load_reg <= 1'b0; // R5
		end
	end

	// Per-channel data, gain, zero, access flag and output latch.
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_chan
			localparam [2:0] IDX = i; // Channel number at the width of the channel selects.
			wire in_hit;   // Input data write to this channel.
			wire eng_hit;  // Corrected result for this channel.
			wire dac_wr;   // Converter data changes this cycle.

			assign in_hit  = hit(wr_req, wr_sel, `OCDC_SEL_INPUT, wr_chan, IDX);
			assign eng_hit = eng_done && (eng_chan == IDX);
			assign dac_wr  = (in_hit && !cal_on) || eng_hit;

			// Power-down only gates the analog side, so writes and loads go on for every channel.
			always @(posedge clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					input_flat_reg[i*12 +: 12] <= `OCDC_CODE_RESET;
					dac_flat_reg[i*12 +: 12]   <= `OCDC_CODE_RESET;
					gain_flat_reg[i*12 +: 12]  <= `OCDC_GAIN_RESET;
					zero_flat_reg[i*12 +: 12]  <= `OCDC_ZERO_RESET;
					latch_data_reg[i*12 +: 12] <= `OCDC_CODE_RESET;
					accessed_reg[i]            <= 1'b0;
				end
				else if (srst)
				begin
					input_flat_reg[i*12 +: 12] <= `OCDC_CODE_RESET;
					dac_flat_reg[i*12 +: 12]   <= `OCDC_CODE_RESET;
					gain_flat_reg[i*12 +: 12]  <= `OCDC_GAIN_RESET;
					zero_flat_reg[i*12 +: 12]  <= `OCDC_ZERO_RESET;
					latch_data_reg[i*12 +: 12] <= `OCDC_CODE_RESET;
					accessed_reg[i]            <= 1'b0; // R8
				end
				else
				begin
					if (hit(wr_req, wr_sel, `OCDC_SEL_GAIN, wr_chan, IDX))
						gain_flat_reg[i*12 +: 12] <= wr_data[15:`OCDC_DATA_LSB];
					if (hit(wr_req, wr_sel, `OCDC_SEL_ZERO, wr_chan, IDX))
						zero_flat_reg[i*12 +: 12] <= wr_data[15:`OCDC_DATA_LSB];
					if (in_hit)
						input_flat_reg[i*12 +: 12] <= wr_data[15:`OCDC_DATA_LSB]; // R2
					if (in_hit && !cal_on)
						dac_flat_reg[i*12 +: 12] <= wr_data[15:`OCDC_DATA_LSB]; // R13
					else if (eng_hit)
						dac_flat_reg[i*12 +: 12] <= eng_result; // R2 R12
					if (load_now && accessed_reg[i])
						latch_data_reg[i*12 +: 12] <= dac_flat_reg[i*12 +: 12]; // R3 R4
					// A write landing in the load cycle keeps the flag so the new code loads later.
					if (dac_wr)
						accessed_reg[i] <= 1'b1; // R4
					else if (load_now)
						accessed_reg[i] <= 1'b0; // R4
				end
			end
		end
	endgenerate

	// Shared correction engine; results come back one cycle after the input write.
	ocdc_correction_engine u_engine (
		.clk        (clk),
		.reset_n    (reset_n),
		.clear      (srst),
		.start      (eng_start),
		.chan_in    (wr_chan),
		.data_in    (wr_data[15:`OCDC_DATA_LSB]),
		.gain_in    (gain_flat_reg[wr_chan*12 +: 12]),
		.zero_in    (zero_flat_reg[wr_chan*12 +: 12]),
		.done_reg   (eng_done),
		.chan_reg   (eng_chan),
		.result_reg (eng_result)
	);

	// Read answers one cycle after the request, whatever the power-down state.
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_data_reg  <= 16'h0000;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			rd_valid_reg <= rd_req; // R11
			if (rd_req && !rd_sel_channel)
				rd_data_reg <= cfg_read;
			else if (rd_req && cfg_reg[`OCDC_BIT_READBACK_SEL])
				rd_data_reg <= {dac_flat_reg[rd_chan*12 +: 12], `OCDC_DATA_LOW_ZERO}; // R1
			else if (rd_req)
				rd_data_reg <= {input_flat_reg[rd_chan*12 +: 12], `OCDC_DATA_LOW_ZERO}; // R1
		end
	end

endmodule // ocdc_config_control

// ==== verilog/ocdc_config_map.vh ====
// Register field positions, reset values and access codes of the octal converter configuration logic.
`ifndef OCDC_CONFIG_MAP_VH
`define OCDC_CONFIG_MAP_VH

// Configuration register field positions.
`define OCDC_BIT_READBACK_SEL 15
`define OCDC_BIT_SYNC_LOAD    14
`define OCDC_BIT_SOFT_RESET   13
`define OCDC_BIT_PD_A         12
`define OCDC_BIT_PD_B         11
`define OCDC_BIT_CAL_EN       10
`define OCDC_BIT_RESERVED     9

// Configuration register reset value and the mask of bits that simply store what is written.
// Only readback select is set after reset, so both groups start powered and reads show converter data.
`define OCDC_CFG_RESET        16'h8000
`define OCDC_CFG_STORE_MASK   16'h9C00

// Channel data, gain and zero words sit in bits 15:4 of a 16-bit access.
`define OCDC_DATA_LSB         4
`define OCDC_DATA_LOW_ZERO    4'h0

// Reset values of the per-channel registers.
`define OCDC_GAIN_RESET       12'h800
`define OCDC_ZERO_RESET       12'h000
`define OCDC_CODE_RESET       12'h000
`define OCDC_CODE_MAX         12'hFFF

// Register select codes of the access port.
`define OCDC_SEL_CONFIG       2'h0
`define OCDC_SEL_INPUT        2'h1
`define OCDC_SEL_GAIN         2'h2
`define OCDC_SEL_ZERO         2'h3

`endif

// ==== verilog/ocdc_correction_engine.v ====
// Gain and zero correction of one channel code, one cycle of latency.
`timescale 1ns/1ps
`include "ocdc_config_map.vh"

module ocdc_correction_engine (
	input  wire        clk,
	input  wire        reset_n,
	input  wire        clear,
	input  wire        start,
	input  wire [2:0]  chan_in,
	input  wire [11:0] data_in,
	input  wire [11:0] gain_in,
	input  wire [11:0] zero_in,
	output reg         done_reg,
	output reg  [2:0]  chan_reg,
	output reg  [11:0] result_reg
);

	wire        [23:0] product;     // Raw code times straight binary gain.
	wire        [12:0] scaled;      // Product divided by the unity gain of 2048.
	wire signed [14:0] summed;      // Scaled code plus the signed zero offset.
	reg         [11:0] result_next; // Clamped corrected code.

	assign product = data_in * gain_in;
	assign scaled  = product[23:11];
	assign summed  = $signed({2'h0, scaled}) + $signed({{3{zero_in[11]}}, zero_in});

	// Clamp to the code range so a large gain or offset saturates instead of wrapping.
	always @*
	begin
		if (summed < 0)
			result_next = `OCDC_CODE_RESET;
		else if (summed > $signed({3'h0, `OCDC_CODE_MAX}))
			result_next = `OCDC_CODE_MAX;
		else
			result_next = summed[11:0];
	end

	// The result is held in flip-flops with a done pulse so the caller knows when to store it.
	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			done_reg   <= 1'b0;
			chan_reg   <= 3'h0;
			result_reg <= `OCDC_CODE_RESET;
		end
		else if (clear)
		begin
			done_reg   <= 1'b0;
			chan_reg   <= 3'h0;
			result_reg <= `OCDC_CODE_RESET;
		end
		else
		begin
			done_reg <= start;
			if (start)
			begin
				chan_reg   <= chan_in;
				result_reg <= result_next;
			end
		end
	end

endmodule // ocdc_correction_engine

// ==== test/ocdc_config_control_asserts.sv ====
// Concurrent property checker of the octal converter configuration control.
`timescale 1ns/1ps
`include "ocdc_config_map.vh"
module ocdc_config_control_asserts (
	input logic        clk,
	input logic        reset_n,
	input logic        wr_req,
	input logic [1:0]  wr_sel,
	input logic [2:0]  wr_chan,
	input logic [15:0] wr_data,
	input logic        rd_req,
	input logic        rd_sel_channel,
	input logic [2:0]  rd_chan,
	input logic [15:0] rd_data_reg,
	input logic        rd_valid_reg,
	input logic        async_load_pin,
	input logic [95:0] latch_data_reg,
	input logic        group_a_powerdown,
	input logic        group_b_powerdown,
	input logic        calibration_enable,
	input logic        sync_load_bit
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Four quiet cycles: pin high and no writes, so nothing may reach the latches.
	sequence idle_s;
		(async_load_pin && !wr_req)[*4] ##0 !sync_load_bit;
	endsequence
	// A configuration write that is not a soft reset, whose fields then simply store.
	sequence cfg_wr_s;
		wr_req && wr_sel == `OCDC_SEL_CONFIG && !wr_data[`OCDC_BIT_SOFT_RESET];
	endsequence
	read_answer_a: assert property (rd_req |=> rd_valid_reg)
		else $error("read request not answered");
	read_pulse_a: assert property (!rd_req |=> !rd_valid_reg)
		else $error("read valid without request");
	reserved_zero_a: assert property (rd_req && !rd_sel_channel |=> rd_data_reg[9:0] == 10'h000)
		else $error("reserved configuration bits read nonzero");
	group_a_pd_a: assert property (cfg_wr_s |=> group_a_powerdown == $past(wr_data[`OCDC_BIT_PD_A]))
		else $error("group A power-down not stored");
	group_b_pd_a: assert property (cfg_wr_s |=> group_b_powerdown == $past(wr_data[`OCDC_BIT_PD_B]))
		else $error("group B power-down not stored");
	cal_enable_a: assert property (cfg_wr_s |=> calibration_enable == $past(wr_data[`OCDC_BIT_CAL_EN]))
		else $error("calibration enable not stored");
	load_clear_a: assert property (sync_load_bit && !calibration_enable && !wr_req |=> !sync_load_bit)
		else $error("sync load bit did not clear");
	pin_low_ignore_a: assert property ((!async_load_pin)[*4] |=> !sync_load_bit)
		else $error("sync load pending while load pin low");
	latch_hold_a: assert property (idle_s |=> $stable(latch_data_reg))
		else $error("latch changed without a load");
endmodule // ocdc_config_control_asserts
bind ocdc_config_control ocdc_config_control_asserts u_chk (.clk(clk), .reset_n(reset_n), .wr_req(wr_req),
	.wr_sel(wr_sel), .wr_chan(wr_chan), .wr_data(wr_data), .rd_req(rd_req), .rd_sel_channel(rd_sel_channel),
	.rd_chan(rd_chan), .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .async_load_pin(async_load_pin),
	.latch_data_reg(latch_data_reg), .group_a_powerdown(group_a_powerdown),
	.group_b_powerdown(group_b_powerdown), .calibration_enable(calibration_enable), .sync_load_bit(sync_load_bit));

// ==== test/ocdc_host_pin.sv ====
// Host-side model that drives the asynchronous load pin.
`timescale 1ns/1ps
module ocdc_host_pin (
	input  logic clk,
	input  logic hold_low,
	output logic async_load_pin
);
	// The pin idles high so that sync load commands are honoured.
	initial async_load_pin = 1'b1;
	// A host port changes just after an edge; holding it low asks for continuous load.
	always @(posedge clk)
		async_load_pin <= !hold_low;
endmodule // ocdc_host_pin

// ==== test/test_octal_dac_config_control.sv ====
// Self-checking bench of the octal converter configuration control.
`timescale 1ns/1ps
module test_octal_dac_config_control;
	logic        clk, reset_n, wr_req, rd_req, rd_sel_channel, hold_low;
	logic [1:0]  wr_sel;
	logic [2:0]  wr_chan, rd_chan;
	logic [15:0] wr_data;
	wire         rd_valid_reg, async_load_pin, pd_a, pd_b, cal_en, ld;
	wire  [15:0] rd_data_reg;
	wire  [95:0] latch_data_reg;
	int          bad_count, n_compared, cycles;
	ocdc_config_control u_dut (.clk(clk), .reset_n(reset_n), .wr_req(wr_req), .wr_sel(wr_sel), .wr_chan(wr_chan),
		.wr_data(wr_data), .rd_req(rd_req), .rd_sel_channel(rd_sel_channel), .rd_chan(rd_chan),
		.rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .async_load_pin(async_load_pin),
		.latch_data_reg(latch_data_reg), .group_a_powerdown(pd_a), .group_b_powerdown(pd_b),
		.calibration_enable(cal_en), .sync_load_bit(ld));
	ocdc_host_pin u_host (.clk(clk), .hold_low(hold_low), .async_load_pin(async_load_pin));
	// The clock runs at 200 MHz.
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// One write, taken at the edge after the fields are set.
	task automatic wr(input logic [1:0] s, input logic [2:0] c, input logic [15:0] d);
		@(posedge clk);
		{wr_req, wr_sel, wr_chan, wr_data} <= {1'b1, s, c, d};
		@(posedge clk);
		wr_req <= 1'b0;
	endtask
	// One read; the answer stands for one cycle only, so it is checked in that cycle.
	task automatic rd(input logic s, input logic [2:0] c, input logic [15:0] exp, input string what);
		@(posedge clk);
		{rd_req, rd_sel_channel, rd_chan} <= {1'b1, s, c};
		@(posedge clk);
		rd_req <= 1'b0;
		#1;
		chk("read valid", 16'h0001, {15'h0000, rd_valid_reg});
		chk(what, exp, rd_data_reg);
	endtask
	// Latch code of one channel, widened for comparison.
	function automatic logic [15:0] lat(input int i);
		return {4'h0, latch_data_reg[12*i +: 12]};
	endfunction
	// Sync load with correction off: pending for one cycle, then latches update.
	task automatic load();
		wr(2'h0, 3'h0, 16'hC000);
		#1;
		chk("load pending", 16'h0001, {15'h0000, ld});
		@(posedge clk);
		#1;
		chk("load cleared", 16'h0000, {15'h0000, ld});
	endtask
	task automatic results();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// A hang is cut short well beyond the under one hundred cycles the tests need.
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			bad_count++;
			results();
		end
	end
	initial
	begin
		{reset_n, wr_req, rd_req, rd_sel_channel, hold_low, wr_sel, wr_chan, rd_chan, wr_data} = 29'h0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(1'b0, 3'h0, 16'h8000, "config reset");
		rd(1'b1, 3'h3, 16'h0000, "channel reset");
		$display("test reset done");
		wr(2'h1, 3'h2, 16'hABC5);
		rd(1'b1, 3'h2, 16'hABC0, "pass-through ch2");
		wr(2'h2, 3'h1, 16'h4000);
		wr(2'h0, 3'h0, 16'h0400);
		wr(2'h1, 3'h1, 16'h8000);
		rd(1'b1, 3'h1, 16'h8000, "raw input ch1");
		wr(2'h0, 3'h0, 16'h8400);
		#1;
		chk("cal enable", 16'h0001, {15'h0000, cal_en});
		rd(1'b1, 3'h1, 16'h4000, "corrected ch1");
		wr(2'h0, 3'h0, 16'h8000);
		#1;
		chk("cal disable", 16'h0000, {15'h0000, cal_en});
		$display("test correction done");
		wr(2'h1, 3'h0, 16'h1230);
		wr(2'h1, 3'h5, 16'h5670);
		load();
		chk("latch ch0", 16'h0123, lat(0));
		chk("latch ch5", 16'h0567, lat(5));
		chk("latch ch1", 16'h0400, lat(1));
		wr(2'h1, 3'h0, 16'h9990);
		load();
		chk("latch ch0", 16'h0999, lat(0));
		chk("latch ch5", 16'h0567, lat(5));
		$display("test load done");
		hold_low <= 1'b1;
		repeat (4) @(posedge clk);
		wr(2'h0, 3'h0, 16'hC000);
		#1;
		chk("load ignored", 16'h0000, {15'h0000, ld});
		hold_low <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test load pin done");
		wr(2'h0, 3'h0, 16'h9000);
		#1;
		chk("power-down", 16'h0002, {14'h0000, pd_a, pd_b});
		rd(1'b0, 3'h0, 16'h9000, "config in power-down");
		chk("latch ch5", 16'h0567, lat(5));
		wr(2'h0, 3'h0, 16'h8800);
		#1;
		chk("power-down", 16'h0001, {14'h0000, pd_a, pd_b});
		rd(1'b1, 3'h5, 16'h5670, "ch5 in power-down");
		$display("test power-down done");
		wr(2'h0, 3'h0, 16'h83FF);
		rd(1'b0, 3'h0, 16'h8000, "reserved bits");
		wr(2'h0, 3'h0, 16'h2000);
		repeat (2) @(posedge clk);
		rd(1'b0, 3'h0, 16'h8000, "config soft reset");
		rd(1'b1, 3'h0, 16'h0000, "ch0 soft reset");
		chk("latch soft reset", 16'h0000, lat(5));
		$display("test soft reset done");
		results();
	end
endmodule // test_octal_dac_config_control
